// *** design/four_lane_io_read_defines.svh ***
`ifndef FOUR_LANE_IO_READ_DEFINES_SVH
`define FOUR_LANE_IO_READ_DEFINES_SVH
// ===========================================================================
// register map of the controller
`define FOUR_LANE_IO_READ_REG_CTRL 4'h0
`define FOUR_LANE_IO_READ_REG_ADDR 4'h1
`define FOUR_LANE_IO_READ_REG_CFG 4'h2
`define FOUR_LANE_IO_READ_REG_STAT 4'h3
`define FOUR_LANE_IO_READ_REG_DATA 4'h4
// ===========================================================================
// field positions
`define FOUR_LANE_IO_READ_CTRL_GO 0
`define FOUR_LANE_IO_READ_CTRL_WIDE 1
`define FOUR_LANE_IO_READ_CTRL_CONT 2
`define FOUR_LANE_IO_READ_CTRL_EXT 3
`define FOUR_LANE_IO_READ_CTRL_LEN_LSB 8
// ===========================================================================
// command and mode codes
`define FOUR_LANE_IO_READ_CMD_READ 8'heb
`define FOUR_LANE_IO_READ_CMD_READ_WIDE 8'hec
`define FOUR_LANE_IO_READ_MODE_KEEP 8'ha0
`define FOUR_LANE_IO_READ_MODE_EXIT 8'h00
`define FOUR_LANE_IO_READ_MODE_KEEP_NIB 4'ha
// ===========================================================================
// timing
`define FOUR_LANE_IO_READ_SCK_MAX_MHZ 104
`define FOUR_LANE_IO_READ_CLK_MHZ 20
`define FOUR_LANE_IO_READ_DUMMY_RST 4'h8
`endif

// *** design/four_lane_io_read_pkg.sv ***
package four_lane_io_read_pkg;
  typedef enum logic [2:0] {
    FOUR_LANE_IO_READ_IDLE = 3'b000,
    FOUR_LANE_IO_READ_INSTR = 3'b001,
    FOUR_LANE_IO_READ_ADDR = 3'b010,
    FOUR_LANE_IO_READ_MODE = 3'b011,
    FOUR_LANE_IO_READ_DUMMY = 3'b100,
    FOUR_LANE_IO_READ_DATA = 3'b101,
    FOUR_LANE_IO_READ_END = 3'b110
  } four_lane_io_read_state_e;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe_n;
  } four_lane_io_read_lanes_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } four_lane_io_read_bus_s;
endpackage

// *** design/four_lane_io_read_host.sv ***
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "four_lane_io_read_defines.svh"
module four_lane_io_read_host #(
  parameter int DIV = 2,
  parameter int MAX_BYTES = 255
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire four_lane_io_read_pkg::four_lane_io_read_bus_s bus,
  output logic [31:0] rdata,
  output logic sck,
  output logic cs_n,
  output four_lane_io_read_pkg::four_lane_io_read_lanes_s lanes,
  input wire logic [3:0] lanes_in
);
  import four_lane_io_read_pkg::*;

  // sck period is 2*DIV clk_sys cycles; 20MHz/4 = 5MHz, far below the limit
  localparam int SCK_MHZ = `FOUR_LANE_IO_READ_CLK_MHZ / (2 * ((DIV < 1) ? 1 : DIV));
  if (DIV < 1 || DIV > 256) begin : g_bad_div
    $error("four_lane_io_read_host: DIV out of range");
  end
  if (SCK_MHZ > `FOUR_LANE_IO_READ_SCK_MAX_MHZ) begin : g_fast_sck
    $error("four_lane_io_read_host: divider gives too fast a serial clock");
  end
  if (MAX_BYTES < 1 || MAX_BYTES > 255) begin : g_bad_len
    $error("four_lane_io_read_host: MAX_BYTES out of range");
  end

  typedef struct packed {
    four_lane_io_read_state_e st;
    logic [7:0] div;
    logic sck;
    logic cs_n;
    four_lane_io_read_lanes_s lanes;
    logic [5:0] cnt;
    logic [39:0] sh;
    logic [7:0] len;
    logic [7:0] done_bytes;
    logic [31:0] addr;
    logic wide;
    logic ext;
    logic cont_req;
    logic in_cont;
    logic [3:0] dummy;
    logic busy;
    logic [7:0] byte_sh;
    logic nib_hi;
    logic [31:0] data;
    logic data_new;
    logic [31:0] rdata;
    logic [2:0] smp;
    logic [3:0] lane_f;
  } four_lane_io_read_regs_s;

  four_lane_io_read_regs_s r, n;
  logic [3:0] in1_r, in2_r, in3_r;

  function automatic logic four_byte(input logic w, input logic e);
    four_byte = w | e;
  endfunction

  // link falls while sck is high: the host shifts on falling edges, samples on rising
  wire logic rise = (r.div == 8'(DIV - 1)) && !r.sck;
  wire logic fall = (r.div == 8'(DIV - 1)) && r.sck;

  always_comb begin
    n = r;
    n.smp = {r.smp[1:0], 1'b0};
    // a lane level counts once the last two capture stages agree
    if (in2_r == in3_r) begin
      n.lane_f = in3_r;
    end
    if (r.div == 8'(DIV - 1)) begin
      n.div = 8'h00;
    end else begin
      n.div = r.div + 8'h01;
    end
    if (bus.wr) begin
      case (bus.addr)
        `FOUR_LANE_IO_READ_REG_ADDR: n.addr = bus.wdata;
        `FOUR_LANE_IO_READ_REG_CFG: n.dummy = bus.wdata[3:0];
        `FOUR_LANE_IO_READ_REG_CTRL: begin
          if (bus.wdata[`FOUR_LANE_IO_READ_CTRL_GO] && !r.busy) begin
            n.wide = bus.wdata[`FOUR_LANE_IO_READ_CTRL_WIDE];
            n.cont_req = bus.wdata[`FOUR_LANE_IO_READ_CTRL_CONT];
            n.ext = bus.wdata[`FOUR_LANE_IO_READ_CTRL_EXT];
            n.len = bus.wdata[`FOUR_LANE_IO_READ_CTRL_LEN_LSB +: 8];
            // counts above MAX_BYTES are cut, not refused
            if (bus.wdata[`FOUR_LANE_IO_READ_CTRL_LEN_LSB +: 8] > 8'(MAX_BYTES)) begin
              n.len = 8'(MAX_BYTES);
            end
            n.busy = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (bus.rd && bus.addr == `FOUR_LANE_IO_READ_REG_DATA) begin
      n.data_new = 1'b0;
    end
    case (bus.addr)
      `FOUR_LANE_IO_READ_REG_ADDR: n.rdata = r.addr;
      `FOUR_LANE_IO_READ_REG_CFG: n.rdata = {28'h0, r.dummy};
      `FOUR_LANE_IO_READ_REG_STAT: n.rdata = {24'h0, r.done_bytes[4:0], r.data_new, r.in_cont, r.busy};
      `FOUR_LANE_IO_READ_REG_DATA: n.rdata = r.data;
      default: n.rdata = 32'h0;
    endcase
    if (!bus.rd) begin
      n.rdata = r.rdata;
    end
    case (r.st)
      FOUR_LANE_IO_READ_IDLE: begin
        n.sck = 1'b0;
        if (r.busy && r.div == 8'(DIV - 1)) begin
          n.cs_n = 1'b0;
          n.done_bytes = 8'h00;
          n.lanes.oe_n = 4'h0;
          if (r.in_cont) begin
            n.st = FOUR_LANE_IO_READ_ADDR;
            n.sh = four_byte(r.wide, r.ext) ? {r.addr, 8'h0} : {r.addr[23:0], 16'h0};
            n.cnt = four_byte(r.wide, r.ext) ? 6'd8 : 6'd6;
            n.lanes.dout = four_byte(r.wide, r.ext) ? r.addr[31:28] : r.addr[23:20];
          end else begin
            n.st = FOUR_LANE_IO_READ_INSTR;
            n.sh = {r.wide ? `FOUR_LANE_IO_READ_CMD_READ_WIDE : `FOUR_LANE_IO_READ_CMD_READ, 32'h0};
            n.cnt = 6'd8;
            n.lanes.oe_n = 4'he;
            n.lanes.dout = {3'b000, n.sh[39]};
          end
        end
      end
      FOUR_LANE_IO_READ_END: begin
        n.sck = 1'b0;
        n.lanes.oe_n = 4'hf;
        if (r.div == 8'(DIV - 1)) begin
          n.cs_n = 1'b1;
          n.busy = 1'b0;
          n.in_cont = r.cont_req;
          n.st = FOUR_LANE_IO_READ_IDLE;
        end
      end
      default: begin
        if (r.div == 8'(DIV - 1)) begin
          n.sck = !r.sck;
        end
        if (rise) begin
          n.cnt = r.cnt - 6'd1;
          // only data clocks are sampled, so the last dummy clock adds no nibble
          n.smp = {2'b00, r.st == FOUR_LANE_IO_READ_DATA};
        end
        if (fall && r.cnt == 6'd0) begin
          case (r.st)
            FOUR_LANE_IO_READ_INSTR: begin
              n.st = FOUR_LANE_IO_READ_ADDR;
              n.sh = four_byte(r.wide, r.ext) ? {r.addr, 8'h0} : {r.addr[23:0], 16'h0};
              n.cnt = four_byte(r.wide, r.ext) ? 6'd8 : 6'd6;
              n.lanes.oe_n = 4'h0;
              n.lanes.dout = four_byte(r.wide, r.ext) ? r.addr[31:28] : r.addr[23:20];
            end
            FOUR_LANE_IO_READ_ADDR: begin
              n.st = FOUR_LANE_IO_READ_MODE;
              n.cnt = 6'd2;
              n.sh = {r.cont_req ? `FOUR_LANE_IO_READ_MODE_KEEP : `FOUR_LANE_IO_READ_MODE_EXIT, 32'h0};
              n.lanes.dout = r.cont_req ? `FOUR_LANE_IO_READ_MODE_KEEP_NIB : 4'h0;
            end
            FOUR_LANE_IO_READ_MODE: begin
              n.st = FOUR_LANE_IO_READ_DUMMY;
              n.cnt = {2'b00, r.dummy};
              n.lanes.oe_n = 4'hf;
              if (r.dummy == 4'h0) begin
                n.st = FOUR_LANE_IO_READ_DATA;
                n.cnt = 6'd2;
              end
            end
            FOUR_LANE_IO_READ_DUMMY: begin
              n.st = FOUR_LANE_IO_READ_DATA;
              n.cnt = 6'd2;
            end
            FOUR_LANE_IO_READ_DATA: begin
              n.cnt = 6'd2;
              if (r.done_bytes == r.len) begin
                n.st = FOUR_LANE_IO_READ_END;
              end
            end
            default: n.st = FOUR_LANE_IO_READ_END;
          endcase
        end else if (fall) begin
          case (r.st)
            FOUR_LANE_IO_READ_INSTR: begin
              n.sh = {r.sh[38:0], 1'b0};
              n.lanes.dout = {3'b000, r.sh[38]};
            end
            FOUR_LANE_IO_READ_ADDR, FOUR_LANE_IO_READ_MODE: begin
              n.sh = {r.sh[35:0], 4'h0};
              n.lanes.dout = r.sh[35:32];
              if (r.st == FOUR_LANE_IO_READ_MODE && r.cnt == 6'd1) begin
                n.lanes.oe_n = 4'hf;
              end
            end
            default: ;
          endcase
        end
      end
    endcase
    // sample the data lanes well after the rising edge, from synchronised copies
    if (r.st == FOUR_LANE_IO_READ_DATA && r.smp[2] && r.done_bytes != r.len) begin
      n.byte_sh = {r.byte_sh[3:0], r.lane_f};
      n.nib_hi = !r.nib_hi;
      if (r.nib_hi) begin
        n.data = {r.data[23:0], r.byte_sh[3:0], r.lane_f};
        n.data_new = 1'b1;
        n.done_bytes = r.done_bytes + 8'h01;
      end
    end
    if (r.st == FOUR_LANE_IO_READ_IDLE) begin
      n.nib_hi = 1'b0;
    end
  end

  // three-stage input capture; data only used after two agreeing stages
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      in1_r <= 4'h0;
      in2_r <= 4'h0;
      in3_r <= 4'h0;
    end else begin
      in1_r <= lanes_in;
      in2_r <= in1_r;
      in3_r <= in2_r;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.st <= FOUR_LANE_IO_READ_IDLE;
      r.cs_n <= 1'b1;
      r.lanes.oe_n <= 4'hf;
      r.dummy <= `FOUR_LANE_IO_READ_DUMMY_RST;
    end else begin
      r <= n;
    end
  end

  assign sck = r.sck;
  assign cs_n = r.cs_n;
  assign lanes = r.lanes;
  assign rdata = r.rdata;

  chk_cs_hold_mode: assert property (@(posedge clk_sys) disable iff (reset)
    (r.st == FOUR_LANE_IO_READ_MODE || r.st == FOUR_LANE_IO_READ_DUMMY) |-> !r.cs_n) else $error("cs released in mode");
  chk_lanes_free_data: assert property (@(posedge clk_sys) disable iff (reset)
    r.st == FOUR_LANE_IO_READ_DATA |-> r.lanes.oe_n == 4'hf) else $error("lanes driven in data");
  chk_instr_lane0: assert property (@(posedge clk_sys) disable iff (reset)
    r.st == FOUR_LANE_IO_READ_INSTR |-> r.lanes.oe_n == 4'he) else $error("instruction not lane zero");
  chk_cont_skip: assert property (@(posedge clk_sys) disable iff (reset)
    (r.st == FOUR_LANE_IO_READ_IDLE && r.in_cont && r.busy && r.div == 8'(DIV - 1)) |=> r.st == FOUR_LANE_IO_READ_ADDR)
    else $error("continuous frame sent instruction");
  chk_mode_two: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r.st == FOUR_LANE_IO_READ_MODE) |-> r.cnt == 6'd2) else $error("mode not two clocks");
  chk_addr_len: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r.st == FOUR_LANE_IO_READ_ADDR) |-> r.cnt == (four_byte(r.wide, r.ext) ? 6'd8 : 6'd6))
    else $error("address length wrong");
  chk_dummy_load: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r.st == FOUR_LANE_IO_READ_DUMMY) |-> r.cnt == {2'b00, r.dummy}) else $error("dummy count wrong");
  chk_mode_code: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r.st == FOUR_LANE_IO_READ_MODE) |-> r.lanes.dout == (r.cont_req ? 4'ha : 4'h0))
    else $error("mode nibble wrong");
  chk_end_cs: assert property (@(posedge clk_sys) disable iff (reset)
    r.st == FOUR_LANE_IO_READ_END |-> ##[1:8] r.cs_n) else $error("frame not closed");
  chk_mode_release: assert property (@(posedge clk_sys) disable iff (reset)
    (r.st == FOUR_LANE_IO_READ_MODE && r.cnt == 6'd1 && fall) |=> r.lanes.oe_n == 4'hf)
    else $error("lanes held in last mode cycle");
  chk_wide_cmd: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r.st == FOUR_LANE_IO_READ_INSTR) |-> r.sh[39:32] == (r.wide ? `FOUR_LANE_IO_READ_CMD_READ_WIDE : `FOUR_LANE_IO_READ_CMD_READ))
    else $error("instruction code wrong");
  cov_wide: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(r.st == FOUR_LANE_IO_READ_ADDR) && four_byte(r.wide, r.ext));
  cov_plain: cover property (@(posedge clk_sys) disable iff (reset) $rose(r.st == FOUR_LANE_IO_READ_INSTR));
  cov_cont: cover property (@(posedge clk_sys) disable iff (reset) r.in_cont && $rose(r.st == FOUR_LANE_IO_READ_ADDR));
  cov_byte: cover property (@(posedge clk_sys) disable iff (reset) $rose(r.data_new));
endmodule

// *** test/four_lane_io_read_mem_model.sv ***
`timescale 1ns/10ps
// ====
// memory on the far side of the lanes
module four_lane_io_read_mem_model #(
  parameter int AW = 24
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] lat,
  input wire logic ext_flag,
  output logic [3:0] io_out = 4'h5
);
  logic cont_r = 1'b0;
  logic wide_r = 1'b0;
  logic drive = 1'b0;
  logic err = 1'b0;
  // four-lane enable bit of the memory, taken as set: the host never programs it
  logic quad_en = 1'b1;
  logic [7:0] instr_r;
  logic [7:0] mode_r;
  logic [7:0] b;
  logic [31:0] addr_r;
  int cyc = 0;
  int hdr;
  int lead;
  int k;
  realtime t_r = 0;
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    logic [31:0] m;
    m = a & ((32'h1 << AW) - 32'h1);
    return m[7:0] + m[15:8] + m[23:16] + m[31:24] + 8'h5c;
  endfunction
  always @(negedge cs_n) begin
    cyc = 0;
    addr_r = 32'h0;
  end
  always @(posedge sck) if (!cs_n) begin
    if (drive && host_oe_n != 4'hf) err = 1'b1;
    if ($realtime - t_r < 9.6) err = 1'b1;
    t_r = $realtime;
    hdr = cont_r ? 0 : 8;
    if (cyc == hdr && !cont_r) wide_r = instr_r == 8'hec || ext_flag;
    lead = hdr + (wide_r ? 8 : 6);
    if (cyc < hdr) instr_r = {instr_r[6:0], io[0]};
    else if (cyc < lead) addr_r = {addr_r[27:0], io};
    else if (cyc < lead + 2) mode_r = {mode_r[3:0], io};
    cyc++;
  end
  // lanes are ignored through the dummy cycles
  always @(negedge sck) if (!cs_n) begin
    k = cyc - lead - 2 - int'(lat);
    if (k >= 0 && quad_en) begin
      drive = 1'b1;
      b = mem_byte(addr_r + 32'(k / 2));
      io_out = k[0] ? b[3:0] : b[7:4];
    end
  end
  // no pull on the lanes, so a released lane shows the inverse
  always @(posedge cs_n) begin
    if (cyc > lead && cyc < lead + 2 + int'(lat)) err = 1'b1;
    if (cyc <= 8) cont_r = 1'b0;
    else cont_r = mode_r[7:4] == 4'ha;
    drive = 1'b0;
    io_out = ~io_out;
  end
endmodule

// *** test/tb_four_lane_io_read_host.sv ***
`timescale 1ns/10ps
`include "four_lane_io_read_defines.svh"
module tb_four_lane_io_read_host;
  import four_lane_io_read_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  four_lane_io_read_bus_s bus = '0;
  logic [31:0] rdata;
  logic sck;
  logic cs_n;
  four_lane_io_read_lanes_s lanes;
  logic [3:0] lanes_in;
  logic [3:0] mdl_io;
  logic [3:0] lat = 4'h8;
  logic ext = 1'b0;
  logic pc = 1'b0;
  logic pw = 1'b0;
  logic [31:0] d;
  int err_count = 0;
  int tests_run = 0;
  assign lanes_in = (lanes.dout & ~lanes.oe_n) | (mdl_io & lanes.oe_n);
  four_lane_io_read_host uut (.clk_sys(clk_sys), .reset(reset), .bus(bus), .rdata(rdata), .sck(sck), .cs_n(cs_n),
    .lanes(lanes), .lanes_in(lanes_in));
  four_lane_io_read_mem_model mdl (.sck(sck), .cs_n(cs_n), .io(lanes_in), .host_oe_n(lanes.oe_n), .lat(lat),
    .ext_flag(ext), .io_out(mdl_io));
  always #25 clk_sys = ~clk_sys;
  // ====
  // bus and compare helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask
  function automatic logic [7:0] eb(input logic [31:0] a);
    return a[7:0] + a[15:8] + a[23:16] + 8'h5c;
  endfunction
  // ====
  // one framed read, then compare what the memory saw
  task automatic op(input logic w, input logic x, input logic c, input logic [31:0] a, input int n,
    input logic [3:0] dm);
    int ec;
    logic ww;
    ww = pc ? pw : (w | x);
    // the host clocks one spare byte after the last counted one
    ec = (pc ? 0 : 8) + (ww ? 8 : 6) + 2 + int'(dm) + 2 * n + 2;
    lat = dm;
    ext = x;
    wr(`FOUR_LANE_IO_READ_REG_CFG, {28'h0, dm});
    wr(`FOUR_LANE_IO_READ_REG_ADDR, a);
    wr(`FOUR_LANE_IO_READ_REG_CTRL, {16'h0, 8'(n), 4'h0, x, c, w, 1'b1});
    // a second start while busy must be dropped
    wr(`FOUR_LANE_IO_READ_REG_CTRL, {16'h0, 8'h1, 4'h0, ~x, ~c, ~w, 1'b1});
    for (int i = 0; i < 400; i++) begin
      rd(`FOUR_LANE_IO_READ_REG_STAT);
      if (d[0] === 1'b0) break;
    end
    check({30'h0, d[1:0]}, {30'h0, c, 1'b0});
    check(32'(mdl.cyc), 32'(ec));
    if (!pc) check({24'h0, mdl.instr_r}, w ? `FOUR_LANE_IO_READ_CMD_READ_WIDE : `FOUR_LANE_IO_READ_CMD_READ);
    check(mdl.addr_r, ww ? a : {8'h0, a[23:0]});
    check({28'h0, mdl.mode_r[7:4]}, {28'h0, c ? `FOUR_LANE_IO_READ_MODE_KEEP_NIB : 4'h0});
    check({31'h0, mdl.cont_r}, {31'h0, c});
    rd(`FOUR_LANE_IO_READ_REG_DATA);
    check(d, {eb(a + n - 4), eb(a + n - 3), eb(a + n - 2), eb(a + n - 1)});
    check({31'h0, mdl.err}, 32'h0);
    pc = c;
    pw = ww;
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ====
  // main sequence
  initial begin
    logic w;
    logic x;
    logic [31:0] r;
    w = 1'b0;
    x = 1'b0;
    void'($urandom(32'h496ff72a));
    repeat (15) @(posedge clk_sys);
    check({26'h0, cs_n, sck, lanes.oe_n}, 32'h2f);
    check(rdata, 32'h0);
    @(posedge clk_sys);
    reset <= 1'b0;
    rd(`FOUR_LANE_IO_READ_REG_CFG);
    check(d, 32'h8);
    rd(4'hf);
    check(d, 32'h0);
    op(1'b0, 1'b0, 1'b0, 32'h00fffffe, 6, 4'h8);
    op(1'b1, 1'b0, 1'b1, 32'h12345678, 4, 4'h3);
    op(1'b1, 1'b0, 1'b1, 32'hab0000fd, 5, 4'h1);
    op(1'b1, 1'b0, 1'b0, 32'h00000000, 4, 4'hf);
    op(1'b0, 1'b1, 1'b0, 32'hfffffffe, 4, 4'h2);
    for (int i = 0; i < 10; i++) begin
      r = $urandom;
      if (!pc) begin
        w = r[0];
        x = r[1];
      end
      op(w, x, r[2], $urandom, 4 + int'(r[5:4]), r[11:8] | 4'h1);
    end
    complete_run();
  end
  initial begin
    #2_000_000;
    err_count++;
    complete_run();
  end
endmodule
